/* rtl/rcs_supervisor.sv */
// Run command supervisor: power-on protection, low-frequency action, wake, restart, standby, stop detect
// Operation
// - Terminal run active at power-on with protection 0 is ignored until re-asserted; here an enabled restart overrides it.
// - Protection 1: terminal run active at power-on starts after initialization.
// - Action low digit: 0 run at limit, 1 stop, 2 sleep; range 0x00-0x12.
// - Action high digit: 0 coast, 1 decelerate, used for stop or sleep.
// - Resume after set frequency stays above limit for wake delay.
// - Restart-after-power-failure setting: 0 off, 1 runs automatically after re-power.
// - Restart waits programmed 0.0-3600.0 s, default 1.0 s, only when enabled.
// - After run accepted, standby for 0.0-600.0 s brake release delay.
// - Stop-speed detection time 0.00-100.00 s, default 0.50 s, qualifies stop speed.
// - Stop speed judged on set speed (mode 0) or feedback speed (mode 1); here mode 0 uses feedback speed outside V/F mode.
// - Coast cuts output at once; decelerate ramps down until stop speed.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rcs_map.svh"
module rcs_supervisor (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Drive context
  input wire logic terminal_channel_i,
  input wire logic run_term_i,
  input wire logic stop_cmd_i,
  input wire logic init_done_i,
  input wire logic [15:0] set_freq_i,
  input wire logic [15:0] lower_limit_i,
  input wire logic [15:0] set_speed_i,
  input wire logic [15:0] fb_speed_i,
  input wire logic vf_mode_i,
  // Supervisor decisions
  output logic run_o,
  output logic clamp_lower_o,
  output logic coast_o,
  output logic decel_o,
  output logic standby_o,
  output logic stop_reached_o,
  output logic sleeping_o
);
  // ==========================================================
  // Registers and bus slave
  // ==========================================================
  logic [15:0] stop_speed_detect_time_q;
  logic [15:0] poweron_run_protection_q;
  logic [15:0] below_limit_action_q;
  logic [15:0] wake_delay_time_q;
  logic [15:0] power_loss_restart_enable_q;
  logic [15:0] power_loss_restart_wait_q;
  logic [15:0] brake_release_standby_delay_q;
  logic [15:0] stop_speed_threshold_q;
  logic [15:0] stop_speed_detect_source_q;
  logic ack_q;
  logic [31:0] dat_q;
  rcs_pkg::rcs_state_t state_q;
  rcs_pkg::rcs_state_t state_d;

  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i;
  // Only the low two byte lanes carry register bits
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wnew = wb_dat_i[15:0];
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge
  wire [15:0] act_w = merge(below_limit_action_q, wnew, wmask);
  wire [15:0] rwait_w = merge(power_loss_restart_wait_q, wnew, wmask);
  wire [15:0] sby_w = merge(brake_release_standby_delay_q, wnew, wmask);
  wire [15:0] det_w = merge(stop_speed_detect_time_q, wnew, wmask);
  wire [15:0] wake_w = merge(wake_delay_time_q, wnew, wmask);
  // Out-of-range writes are dropped so the setting keeps a legal value
  wire act_ok = (act_w <= `RCS_MAX_BELOW_ACTION) && (act_w[`RCS_ACT_LO] <= `RCS_ACT_SLEEP);
  wire rwait_ok = rwait_w <= `RCS_MAX_RESTART_WAIT;
  wire sby_ok = sby_w <= `RCS_MAX_STANDBY_DELAY;
  wire det_ok = det_w <= `RCS_MAX_STOP_DET_TIME;
  wire wake_ok = wake_w <= `RCS_MAX_RESTART_WAIT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_speed_detect_time_q <= `RCS_RST_STOP_DET_TIME;
      poweron_run_protection_q <= `RCS_RST_PWRON_PROT;
      below_limit_action_q <= `RCS_RST_BELOW_ACTION;
      wake_delay_time_q <= `RCS_RST_WAKE_DELAY;
      power_loss_restart_enable_q <= `RCS_RST_RESTART_EN;
      power_loss_restart_wait_q <= `RCS_RST_RESTART_WAIT;
      brake_release_standby_delay_q <= `RCS_RST_STANDBY_DELAY;
      stop_speed_threshold_q <= `RCS_RST_STOP_THRESH;
      stop_speed_detect_source_q <= `RCS_RST_STOP_SOURCE;
    end else if (wr) begin
      case (wb_adr_i)
        `RCS_ADDR_STOP_DET_TIME: if (det_ok) stop_speed_detect_time_q <= det_w;
        `RCS_ADDR_PWRON_PROT: poweron_run_protection_q <= {15'h0, merge(poweron_run_protection_q, wnew, wmask) != 16'h0};
        `RCS_ADDR_BELOW_ACTION: if (act_ok) below_limit_action_q <= act_w;
        `RCS_ADDR_WAKE_DELAY: if (wake_ok) wake_delay_time_q <= wake_w;
        `RCS_ADDR_RESTART_EN: power_loss_restart_enable_q <= {15'h0, merge(power_loss_restart_enable_q, wnew, wmask) != 16'h0};
        `RCS_ADDR_RESTART_WAIT: if (rwait_ok) power_loss_restart_wait_q <= rwait_w;
        `RCS_ADDR_STANDBY_DELAY: if (sby_ok) brake_release_standby_delay_q <= sby_w;
        `RCS_ADDR_STOP_THRESH: stop_speed_threshold_q <= merge(stop_speed_threshold_q, wnew, wmask);
        `RCS_ADDR_STOP_SOURCE: stop_speed_detect_source_q <= {15'h0, merge(stop_speed_detect_source_q, wnew, wmask) != 16'h0};
        default: ;
      endcase
    end
  end

  wire [15:0] status_w = {9'h0, state_q};
  logic [15:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      `RCS_ADDR_STOP_DET_TIME: rd_mux = stop_speed_detect_time_q;
      `RCS_ADDR_PWRON_PROT: rd_mux = poweron_run_protection_q;
      `RCS_ADDR_BELOW_ACTION: rd_mux = below_limit_action_q;
      `RCS_ADDR_WAKE_DELAY: rd_mux = wake_delay_time_q;
      `RCS_ADDR_RESTART_EN: rd_mux = power_loss_restart_enable_q;
      `RCS_ADDR_RESTART_WAIT: rd_mux = power_loss_restart_wait_q;
      `RCS_ADDR_STANDBY_DELAY: rd_mux = brake_release_standby_delay_q;
      `RCS_ADDR_STOP_THRESH: rd_mux = stop_speed_threshold_q;
      `RCS_ADDR_STOP_SOURCE: rd_mux = stop_speed_detect_source_q;
      `RCS_ADDR_STATUS: rd_mux = status_w;
      default: rd_mux = 16'h0;
    endcase
  end

  // Ack one cycle after the strobe, dropped the next cycle; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        dat_q <= {16'h0, rd_mux};
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Inputs, tick and edge detection
  // ==========================================================
  logic run_s;
  rcs_sync u_sync_run (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(run_term_i),
    .q_o(run_s)
  );
  logic [31:0] tick_cnt_q;
  logic tick;
  assign tick = tick_cnt_q == (`RCS_TICK_CYC - 32'd1);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  logic run_prev_q;
  logic prot_q;
  logic first_q;
  // Only an enabled restart goes through its wait; protection 1 alone starts from idle
  wire restart_now = terminal_channel_i && run_s && power_loss_restart_enable_q[0];
  wire run_rise = run_s && !run_prev_q;
  // Run request gated by the power-on protection latch
  wire run_req = run_s && !prot_q;

  // ==========================================================
  // Low-frequency decode and timers
  // ==========================================================
  wire [3:0] act_sel = below_limit_action_q[`RCS_ACT_LO];
  wire [3:0] act_sty = below_limit_action_q[`RCS_ACT_HI];
  // Action only has meaning with a non-zero lower limit
  wire below = (lower_limit_i != 16'h0) && (set_freq_i < lower_limit_i);
  wire above = set_freq_i > lower_limit_i;
  wire low_stop = below && (act_sel == `RCS_ACT_STOP || act_sel == `RCS_ACT_SLEEP);
  wire style_decel = act_sty == `RCS_STYLE_DECEL;

  logic st_standby;
  logic st_lowhold;
  logic st_rwait;
  logic sby_done;
  logic wake_done;
  logic rw_done;
  logic det_done;
  assign st_standby = state_q == rcs_pkg::RCS_STANDBY;
  assign st_lowhold = state_q == rcs_pkg::RCS_LOW_HOLD;
  assign st_rwait = state_q == rcs_pkg::RCS_RESTART_WAIT;

  rcs_timer u_sby (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(st_standby), .tick_i(tick),
    .limit_i(brake_release_standby_delay_q), .scale_i(`RCS_TENTH_TICKS), .done_o(sby_done)
  );
  // Wake timer runs only while frequency stays above the limit
  rcs_timer u_wake (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(st_lowhold && above), .tick_i(tick),
    .limit_i(wake_delay_time_q), .scale_i(`RCS_TENTH_TICKS), .done_o(wake_done)
  );
  rcs_timer u_rwait (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(st_rwait), .tick_i(tick),
    .limit_i(power_loss_restart_wait_q), .scale_i(`RCS_TENTH_TICKS), .done_o(rw_done)
  );

  // Stop speed judged on set or feedback speed, held for the detection time
  wire [15:0] judge_speed = (stop_speed_detect_source_q[0] || !vf_mode_i) ? fb_speed_i : set_speed_i;
  wire at_stop_speed = judge_speed <= stop_speed_threshold_q;
  rcs_timer u_det (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(at_stop_speed), .tick_i(tick),
    .limit_i(stop_speed_detect_time_q), .scale_i(`RCS_UNIT_TICKS), .done_o(det_done)
  );

  // ==========================================================
  // Supervisor state machine
  // ==========================================================
  logic coast_q;
  logic low_origin_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      rcs_pkg::RCS_INIT: begin
        if (init_done_i) begin
          if (restart_now) state_d = rcs_pkg::RCS_RESTART_WAIT;
          else state_d = rcs_pkg::RCS_IDLE;
        end
      end
      rcs_pkg::RCS_IDLE: if (run_req && !stop_cmd_i) state_d = rcs_pkg::RCS_STANDBY;
      rcs_pkg::RCS_RESTART_WAIT: if (rw_done) state_d = rcs_pkg::RCS_STANDBY;
      rcs_pkg::RCS_STANDBY: begin
        if (stop_cmd_i || !run_req) state_d = rcs_pkg::RCS_IDLE;
        else if (sby_done) state_d = rcs_pkg::RCS_RUN;
      end
      rcs_pkg::RCS_RUN: begin
        if (stop_cmd_i || !run_req) state_d = rcs_pkg::RCS_STOPPING;
        else if (low_stop) state_d = rcs_pkg::RCS_STOPPING;
      end
      rcs_pkg::RCS_STOPPING: begin
        // Coast ends at once, deceleration ends at the stop speed
        if (coast_q || det_done) begin
          state_d = low_origin_q ? rcs_pkg::RCS_LOW_HOLD : rcs_pkg::RCS_IDLE;
        end
      end
      rcs_pkg::RCS_LOW_HOLD: begin
        if (stop_cmd_i || !run_req) state_d = rcs_pkg::RCS_IDLE;
        else if (wake_done) state_d = rcs_pkg::RCS_RUN;
      end
      default: state_d = rcs_pkg::RCS_INIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= rcs_pkg::RCS_INIT;
      run_prev_q <= 1'b0;
      prot_q <= 1'b0;
      first_q <= 1'b1;
      coast_q <= 1'b0;
      low_origin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_prev_q <= run_s;
      // Power-on sampling of the terminal run level at initialization end
      if (state_q == rcs_pkg::RCS_INIT && init_done_i && first_q) begin
        first_q <= 1'b0;
        if (terminal_channel_i && run_s) begin
          // An enabled restart overrides protection, else its wait would end in idle
          prot_q <= !(poweron_run_protection_q[0] || power_loss_restart_enable_q[0]);
        end
      end else if (prot_q && (!run_s || run_rise)) begin
        prot_q <= 1'b0;
      end
      if (state_q == rcs_pkg::RCS_RUN && state_d == rcs_pkg::RCS_STOPPING) begin
        low_origin_q <= low_stop && !stop_cmd_i && run_req;
        coast_q <= (low_stop && !stop_cmd_i && run_req) ? !style_decel : 1'b0;
      end
    end
  end

  assign run_o = state_q == rcs_pkg::RCS_RUN;
  assign clamp_lower_o = run_o && below && act_sel == `RCS_ACT_RUN_LIMIT;
  assign coast_o = (state_q == rcs_pkg::RCS_STOPPING) && coast_q;
  assign decel_o = (state_q == rcs_pkg::RCS_STOPPING) && !coast_q;
  assign standby_o = st_standby || st_rwait;
  assign stop_reached_o = det_done;
  assign sleeping_o = st_lowhold && act_sel == `RCS_ACT_SLEEP;

  // ==========================================================
  // Checks
  // ==========================================================
  // A low-frequency cut is the only path that picks a stop style
  sequence s_low_cut;
    run_o && low_stop && !stop_cmd_i && run_req;
  endsequence
  a_low_stop_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    s_low_cut |=> !run_o)
    else $error("run kept while set frequency below limit with stop action");
  a_style_coast: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_low_cut and !style_decel) |=> coast_o)
    else $error("coast style not applied");
  a_style_decel: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_low_cut and style_decel) |=> decel_o)
    else $error("decelerate style not applied");
  a_wake_needs_above: assert property (@(posedge clk_i) disable iff (rst_i)
    st_lowhold && !above |=> !run_o)
    else $error("woke without frequency above limit");
  a_prot_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_q && state_q == rcs_pkg::RCS_IDLE |=> state_q != rcs_pkg::RCS_STANDBY)
    else $error("protected run input started the drive");
  // Protection may only lift after the input was seen low or freshly raised
  a_prot_release: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(prot_q) |-> !$past(run_s) || !$past(run_prev_q))
    else $error("power-on protection lifted with run input still held");
  a_standby_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(run_o) |-> $past(st_standby) || $past(st_lowhold))
    else $error("run began without standby");
  a_standby_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st_standby && !sby_done |=> !run_o)
    else $error("run began before the standby delay elapsed");
  a_coast_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
    coast_o |=> !coast_o)
    else $error("coast stop lasted more than one cycle");
  a_restart_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    st_rwait && !rw_done |=> !run_o)
    else $error("restart ran before wait elapsed");
  a_restart_route: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == rcs_pkg::RCS_INIT && init_done_i && restart_now |=> st_rwait)
    else $error("enabled restart skipped its wait");
  a_clamp_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    clamp_lower_o |-> act_sel == `RCS_ACT_RUN_LIMIT && below)
    else $error("clamp without run-at-limit action");
  a_detect_src: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_reached_o |-> at_stop_speed)
    else $error("stop speed flagged above threshold");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
endmodule : rcs_supervisor
`default_nettype wire

/* rtl/rcs_map.svh */
// Register map, field positions, reset values and timing constants of the run command supervisor
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// Word byte addresses on the Wishbone slave
`define RCS_ADDR_STOP_DET_TIME 6'h00
`define RCS_ADDR_PWRON_PROT 6'h04
`define RCS_ADDR_BELOW_ACTION 6'h08
`define RCS_ADDR_WAKE_DELAY 6'h0c
`define RCS_ADDR_RESTART_EN 6'h10
`define RCS_ADDR_RESTART_WAIT 6'h14
`define RCS_ADDR_STANDBY_DELAY 6'h18
`define RCS_ADDR_STOP_THRESH 6'h1c
`define RCS_ADDR_STOP_SOURCE 6'h20
`define RCS_ADDR_STATUS 6'h24
// Reset values (time registers in 0.1 s, detect time in 0.01 s)
`define RCS_RST_STOP_DET_TIME 16'h0032
`define RCS_RST_PWRON_PROT 16'h0000
`define RCS_RST_BELOW_ACTION 16'h0000
`define RCS_RST_WAKE_DELAY 16'h0000
`define RCS_RST_RESTART_EN 16'h0000
`define RCS_RST_RESTART_WAIT 16'h000a
`define RCS_RST_STANDBY_DELAY 16'h0000
`define RCS_RST_STOP_THRESH 16'h0032
`define RCS_RST_STOP_SOURCE 16'h0000
// Upper limits of the settings
`define RCS_MAX_BELOW_ACTION 16'h0012
`define RCS_MAX_RESTART_WAIT 16'h8ca0
`define RCS_MAX_STANDBY_DELAY 16'h1770
`define RCS_MAX_STOP_DET_TIME 16'h2710
// Digit fields of the below-limit action setting
`define RCS_ACT_LO 3:0
`define RCS_ACT_HI 7:4
`define RCS_ACT_RUN_LIMIT 4'h0
`define RCS_ACT_STOP 4'h1
`define RCS_ACT_SLEEP 4'h2
`define RCS_STYLE_DECEL 4'h1
// Timing: tick of 0.01 s at 20 MHz
`define RCS_CLK_HZ 32'd20000000
`define RCS_TICK_MS 32'd10
`define RCS_TICK_CYC ((`RCS_CLK_HZ / 32'd1000) * `RCS_TICK_MS)
`define RCS_TENTH_TICKS 16'h000a
`define RCS_UNIT_TICKS 16'h0001
`endif

/* rtl/rcs_pkg.sv */
// Types of the run command supervisor
package rcs_pkg;
  typedef enum logic [6:0] {
    RCS_INIT = 7'h01,
    RCS_IDLE = 7'h02,
    RCS_STANDBY = 7'h04,
    RCS_RUN = 7'h08,
    RCS_STOPPING = 7'h10,
    RCS_LOW_HOLD = 7'h20,
    RCS_RESTART_WAIT = 7'h40
  } rcs_state_t;
endpackage : rcs_pkg

/* rtl/rcs_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module rcs_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic q_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_q <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_q <= s3_q;
      end
    end
  end
  assign q_o = q_q;
endmodule : rcs_sync
`default_nettype wire

/* rtl/rcs_timer.sv */
// Tick counter that flags when a programmed count has been reached
`timescale 1ns/1ns
`default_nettype none
module rcs_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [15:0] limit_i,
  input wire logic [15:0] scale_i,
  output logic done_o
);
  // Counts ticks times scale so 0.1 s settings share the 0.01 s tick
  logic [31:0] cnt_q;
  logic [31:0] target;
  assign target = 32'(limit_i) * 32'(scale_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= 32'h0;
    end else if (tick_i && cnt_q < target) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  assign done_o = run_i && (cnt_q >= target);
endmodule : rcs_timer
`default_nettype wire

/* verif/rcs_drive_model.sv */
// Drive-side partner: terminal run pin, initialization sequencing and a crude speed plant
`timescale 1ns/1ns
`default_nettype none
module rcs_drive_model (
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic run_req_i,
  input wire logic [15:0] freq_i,
  input wire logic run_i,
  input wire logic decel_i,
  output logic run_term_o,
  output logic init_done_o,
  output logic [15:0] speed_o
);
  logic [3:0] init_cnt_q;
  // ==========
  // Init sequencing
  // Init ends 15 cycles after power, so the pin is stable well before sampling
  always_ff @(posedge clk_i) begin
    run_term_o <= run_req_i;
    if (!power_i) init_cnt_q <= 4'h0;
    else if (init_cnt_q != 4'hf) init_cnt_q <= init_cnt_q + 4'h1;
  end
  assign init_done_o = (init_cnt_q == 4'hf);
  // ==========
  // Speed plant
  // No output means no speed at once; real shafts coast longer, but only stop decisions matter here
  always_ff @(posedge clk_i) begin
    if (decel_i) speed_o <= (speed_o > 16'h0010) ? speed_o - 16'h0010 : 16'h0000;
    else if (run_i) speed_o <= freq_i;
    else speed_o <= 16'h0000;
  end
endmodule : rcs_drive_model
`default_nettype wire

/* verif/rcs_supervisor_tb.sv */
// Self-checking bench for the run command supervisor
`timescale 1ns/1ns
`default_nettype none
`include "rcs_map.svh"
module rcs_supervisor_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [5:0] wb_adr = 6'h00;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic chan = 1'b1, stop_cmd = 1'b0, vf_mode = 1'b1, power = 1'b0, run_req = 1'b0, clr = 1'b0;
  // Feedback is driven on its own so the two stop-speed sources can be told apart
  logic [15:0] freq = 16'h0200, limit = 16'h0080, speed, fb = 16'h0000;
  logic run_term, init_done, run_o, clamp, coast, decel, standby, reached, sleeping;
  logic [3:0] seen = 4'h0;
  int err_count = 0;
  int checked = 0;
  logic [15:0] rst_val [10] = '{16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000,
    16'h0032, 16'h0000, 16'h0001};
  logic [5:0] bad_adr [9] = '{6'h08, 6'h08, 6'h08, 6'h14, 6'h14, 6'h18, 6'h00, 6'h24, 6'h28};
  logic [15:0] bad_wr [9] = '{16'h0013, 16'h0003, 16'h0012, 16'h8ca1, 16'h8ca0, 16'h1771, 16'h2711,
    16'h0055, 16'h1234};
  logic [15:0] bad_exp [9] = '{16'h0000, 16'h0000, 16'h0012, 16'h000a, 16'h8ca0, 16'h0000, 16'h0032,
    16'h0001, 16'h0000};
  logic [7:0] acts [5] = '{8'h00, 8'h01, 8'h11, 8'h02, 8'h12};

  always #25 clk_i = ~clk_i;
  // Pulses such as coast last one cycle, so they are latched until cleared
  always @(posedge clk_i) seen <= clr ? 4'h0 : seen | {standby === 1'b1, reached === 1'b1,
    decel === 1'b1, coast === 1'b1};

  rcs_supervisor u_rcs_supervisor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .terminal_channel_i(chan), .run_term_i(run_term), .stop_cmd_i(stop_cmd),
    .init_done_i(init_done), .set_freq_i(freq), .lower_limit_i(limit), .set_speed_i(speed),
    .fb_speed_i(fb), .vf_mode_i(vf_mode), .run_o(run_o), .clamp_lower_o(clamp), .coast_o(coast),
    .decel_o(decel), .standby_o(standby), .stop_reached_o(reached), .sleeping_o(sleeping));

  rcs_drive_model u_rcs_drive_model (.clk_i(clk_i), .power_i(power), .run_req_i(run_req), .freq_i(freq),
    .run_i(run_o), .decel_i(decel), .run_term_o(run_term), .init_done_o(init_done), .speed_o(speed));

  // ==========
  // Helpers
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [5:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) err_count++;
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [5:0] adr, input logic [15:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, {16'h0000, d}, q);
  endtask : wr

  task automatic rd_chk(input logic [5:0] adr, input logic [15:0] e, input string nm);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 32'h0, q);
    chk(nm, q, {16'h0000, e});
  endtask : rd_chk

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (run_o !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_run

  task automatic pulse_clr();
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask : pulse_clr

  // Delays are left at zero: one tick is 200000 cycles, too long for this run
  task automatic power_up(input logic [15:0] prot, input logic [15:0] ren, input logic run);
    @(posedge clk_i);
    rst_i <= 1'b1;
    power <= 1'b0;
    run_req <= run;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`RCS_ADDR_PWRON_PROT, prot);
    wr(`RCS_ADDR_RESTART_EN, ren);
    wr(`RCS_ADDR_RESTART_WAIT, 16'h0000);
    wr(`RCS_ADDR_STOP_DET_TIME, 16'h0000);
    power <= 1'b1;
  endtask : power_up

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // ==========
  // Tests
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(6'(i * 4), rst_val[i], "reset value");
    for (int i = 0; i < 9; i++) begin
      wr(bad_adr[i], bad_wr[i]);
      rd_chk(bad_adr[i], bad_exp[i], "range limit");
    end
    $display("Test registers done");
    power_up(16'h0000, 16'h0000, 1'b1);
    repeat (60) @(posedge clk_i);
    chk("protected run", run_o, 1'b0);
    rd_chk(`RCS_ADDR_STATUS, 16'h0002, "protected state");
    run_req <= 1'b0;
    repeat (20) @(posedge clk_i);
    pulse_clr();
    run_req <= 1'b1;
    wait_run(1'b1);
    chk("rearmed run", run_o, 1'b1);
    chk("standby seen", seen[3], 1'b1);
    $display("Test protection done");
    power_up(16'h0001, 16'h0000, 1'b1);
    wait_run(1'b1);
    chk("auto start", run_o, 1'b1);
    power_up(16'h0000, 16'h0001, 1'b1);
    wait_run(1'b1);
    chk("restart run", run_o, 1'b1);
    $display("Test restart done");
    for (int i = 0; i < 5; i++) begin
      freq <= 16'h0200;
      wr(`RCS_ADDR_BELOW_ACTION, {8'h00, acts[i]});
      wait_run(1'b1);
      pulse_clr();
      freq <= 16'h0020;
      repeat (60) @(posedge clk_i);
      chk("low run", run_o, acts[i][3:0] == 4'h0);
      chk("low clamp", clamp, acts[i][3:0] == 4'h0);
      chk("low sleep", sleeping, acts[i][3:0] == 4'h2);
      chk("coast style", seen[0], acts[i][3:0] != 4'h0 && acts[i][7:4] == 4'h0);
      chk("decel style", seen[1], acts[i][3:0] != 4'h0 && acts[i][7:4] == 4'h1);
      rd_chk(`RCS_ADDR_STATUS, (acts[i][3:0] == 4'h0) ? 16'h0008 : 16'h0020, "low state");
      freq <= 16'h0200;
      wait_run(1'b1);
      chk("wake run", run_o, 1'b1);
    end
    $display("Test below limit done");
    pulse_clr();
    stop_cmd <= 1'b1;
    repeat (80) @(posedge clk_i);
    chk("stop run", run_o, 1'b0);
    chk("stop decel", seen[1], 1'b1);
    chk("stop reached", seen[2], 1'b1);
    fb <= 16'h0100;
    wr(`RCS_ADDR_STOP_SOURCE, 16'h0001);
    repeat (2) @(posedge clk_i);
    chk("feedback source", reached, 1'b0);
    vf_mode <= 1'b0;
    wr(`RCS_ADDR_STOP_SOURCE, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk("set source outside vf", reached, 1'b0);
    vf_mode <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("set source in vf", reached, 1'b1);
    stop_cmd <= 1'b0;
    $display("Test stop done");
    give_verdict();
  end

  initial begin
    repeat (10000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule : rcs_supervisor_tb
`default_nettype wire
